// >>> sec_top.sv
/*
  Slice boundary error handling and macroblock filling for the bitstream decoder unit,
  with pipeline flush, watchdog and stream-switch gating, behind an AXI4-Lite slave.
  Assumes one clock; the bitstream decoder pulses mb_done and slice_end; slice commands
  arrive on a valid/ready port from the command streamer.
*/
// Contract
// - AVC and VC1 flush at slice end; MPEG2 flushes on picture-state command. No flush is given when slice_end comes with the last macroblock's mb_done.
// - Errors are handled only at slice boundaries or between pictures.
// - First slice of a new picture clears the current position to zero.
// - Picture end found by comparing position with picture size; never decode beyond.
// - Read-only status bit shows filling of missing macroblocks in progress.
// - Sticky slice error bit set on VLD, decoded data or MPR error; writing one to it clears it.
// - Decoded macroblocks are counted as the raster position in the picture.
// - Compare position with slice first position; position below slice start starts concealment immediately.
// - Position above slice start is overwritten with start; decoding resumes there.
// - Position already at picture end discards remaining input data.
// - Gap fill starts at position minus min of prior count and rewind limit, the limit doubled for MBAFF.
// - Fill copies co-located macroblocks from the named concealment frame store.
// - Phantom slice at or beyond picture size fills to end then stops.
// - All filling and decoding stop at picture size; no carry into next picture.
// - Watchdog reaching its preset threshold resets the decode engine.
// - VC1 snoops next slice start and stops exactly at the last macroblock.
// - VC1 flushes surplus slice bitstream after the last macroblock.
// - Premature VC1 end conceals from next address if enabled, else leaves hole.
// - VC1 intra concealment sends one predicted DC per block then end-of-block.
// - VC1 inter concealment emits one-vector skip P frame macroblocks, zero motion.
// - Stream switching is allowed only at picture boundaries.
`timescale 1ns/100ps
module sec_top
  import sec_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sec_cmd_t cmd,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic mb_done,
  input wire logic slice_end,
  input wire logic vld_error,
  input wire logic data_error,
  input wire logic mpr_error,
  output logic decode_enable,
  output logic discard_data,
  output sec_fill_t fill_beat,
  output logic fill_valid,
  input wire logic fill_ready,
  output logic pipe_flush,
  output logic end_of_slice,
  output logic engine_reset,
  output logic stream_switch_ok
);
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_FILL, ST_DECODE, ST_DRAIN, ST_DONE} sec_state_t;

  sec_state_t state_reg;
  sec_cmd_t cmd_reg;
  sec_codec_t codec_reg;
  logic [31:0] ctrl_reg;
  logic [15:0] pic_size_reg;
  logic [31:0] wdog_limit_reg;
  logic [31:0] wdog_count_reg;
  logic [15:0] current_mb_position_reg;
  logic [15:0] prior_decoded_mb_count_reg;
  logic [15:0] slice_count_reg;
  logic [15:0] fill_end_reg;
  logic [15:0] fill_pos_reg;
  logic new_pic_reg;
  logic fill_active_reg;
  logic slice_err_reg;
  logic wdog_hit_reg;
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic cmd_take;
  logic fill_take;
  logic wdog_fire;
  logic [15:0] rewind_limit;
  logic [15:0] rewind;
  logic [15:0] stop_pos;
  logic [15:0] start_clip;
  logic mb_last;
  logic progress;

  // Apply byte strobes to a stored word
  function automatic logic [31:0] sec_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction : sec_merge

  // Handshake terms and position arithmetic
  assign cmd_ready = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
  assign cmd_take = cmd_valid && cmd_ready;
  assign fill_valid = (state_reg == ST_FILL);
  assign fill_take = fill_valid && fill_ready;
  assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rewind_limit = {8'h00, ctrl_reg[SEC_CTRL_REWIND_MSB:SEC_CTRL_REWIND_LSB]};
  assign rewind = ctrl_reg[SEC_CTRL_MBAFF_BIT] ? {rewind_limit[14:0], 1'b0} : rewind_limit;
  assign start_clip = (cmd_reg.slice_first_mb_position < pic_size_reg) ?
                      cmd_reg.slice_first_mb_position : pic_size_reg;
  assign stop_pos = (codec_reg == SEC_CODEC_VC1 && cmd_reg.next_slice_first_mb_position < pic_size_reg) ?
                    cmd_reg.next_slice_first_mb_position : pic_size_reg;
  assign mb_last = (current_mb_position_reg + 16'h0001) >= stop_pos;
  assign decode_enable = (state_reg == ST_DECODE);
  assign discard_data = (state_reg == ST_DRAIN);
  assign stream_switch_ok = ((state_reg == ST_IDLE) && new_pic_reg) || (state_reg == ST_DONE);
  assign progress = mb_done || fill_take || cmd_take;
  assign wdog_fire = (wdog_limit_reg != 32'h0000_0000) && (wdog_count_reg >= wdog_limit_reg);

  // Slice sequencing, positions and filling
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      codec_reg <= SEC_CODEC_AVC;
      current_mb_position_reg <= 16'h0000;
      prior_decoded_mb_count_reg <= 16'h0000;
      slice_count_reg <= 16'h0000;
      fill_pos_reg <= 16'h0000;
      fill_end_reg <= 16'h0000;
      fill_beat <= '0;
      new_pic_reg <= 1'b1;
      fill_active_reg <= 1'b0;
      pipe_flush <= 1'b0;
      end_of_slice <= 1'b0;
    end
    else
    begin
      pipe_flush <= 1'b0;
      end_of_slice <= 1'b0;
      if (wdog_fire)
      begin
        state_reg <= ST_IDLE;
        fill_active_reg <= 1'b0;
        new_pic_reg <= 1'b1;
      end
      else
      begin
        case (state_reg)
          ST_IDLE, ST_DONE:
          begin
            if (cmd_take && cmd.kind == SEC_CMD_PICTURE)
            begin
              codec_reg <= cmd.codec;
              new_pic_reg <= 1'b1;
              state_reg <= ST_IDLE;
              if (cmd.codec == SEC_CODEC_MPEG2)
                pipe_flush <= 1'b1;
            end
            else if (cmd_take)
            begin
              cmd_reg <= cmd;
              state_reg <= ST_CHECK;
              if (new_pic_reg)
              begin
                current_mb_position_reg <= 16'h0000;
                prior_decoded_mb_count_reg <= 16'h0000;
                new_pic_reg <= 1'b0;
              end
            end
          end
          ST_CHECK:
          begin
            slice_count_reg <= 16'h0000;
            fill_beat.frame_store <= cmd_reg.conceal_frame_store;
            fill_beat.mode <= SEC_FILL_COPY;
            if (current_mb_position_reg >= pic_size_reg)
              state_reg <= (cmd_reg.data_len == 24'h000000) ? ST_DONE : ST_DRAIN;
            else if (current_mb_position_reg == cmd_reg.slice_first_mb_position)
              state_reg <= ST_DECODE;
            // overlap, jump back to slice start
            else if (current_mb_position_reg > cmd_reg.slice_first_mb_position)
            begin
              current_mb_position_reg <= cmd_reg.slice_first_mb_position;
              state_reg <= ST_DECODE;
            end
            else
            begin
              fill_pos_reg <= current_mb_position_reg -
                ((prior_decoded_mb_count_reg < rewind) ? prior_decoded_mb_count_reg : rewind);
              fill_beat.position <= current_mb_position_reg -
                ((prior_decoded_mb_count_reg < rewind) ? prior_decoded_mb_count_reg : rewind);
              fill_end_reg <= start_clip;
              fill_active_reg <= 1'b1;
              state_reg <= ST_FILL;
            end
          end
          ST_FILL:
          begin
            if (fill_take)
            begin
              fill_pos_reg <= fill_pos_reg + 16'h0001;
              fill_beat.position <= fill_pos_reg + 16'h0001;
              current_mb_position_reg <= fill_pos_reg + 16'h0001;
              // stop at target, never past picture
              if ((fill_pos_reg + 16'h0001) >= fill_end_reg)
              begin
                fill_active_reg <= 1'b0;
                if (fill_end_reg >= pic_size_reg)
                  state_reg <= (cmd_reg.data_len == 24'h000000) ? ST_DONE : ST_DRAIN;
                else if (codec_reg == SEC_CODEC_VC1 && fill_end_reg == stop_pos)
                begin
                  state_reg <= ST_IDLE;
                  pipe_flush <= 1'b1;
                end
                else
                  state_reg <= ST_DECODE;
              end
            end
          end
          ST_DECODE:
          begin
            if (mb_done)
            begin
              current_mb_position_reg <= current_mb_position_reg + 16'h0001;
              slice_count_reg <= slice_count_reg + 16'h0001;
              prior_decoded_mb_count_reg <= slice_count_reg + 16'h0001;
            end
            // act only at the slice boundary
            if (slice_end && !(mb_done && mb_last))
            begin
              prior_decoded_mb_count_reg <= slice_count_reg + {15'h0000, mb_done};
              if (codec_reg == SEC_CODEC_VC1 && ctrl_reg[SEC_CTRL_CONCEAL_BIT])
              begin
                fill_pos_reg <= current_mb_position_reg + {15'h0000, mb_done};
                fill_beat.position <= current_mb_position_reg + {15'h0000, mb_done};
                fill_end_reg <= stop_pos;
                // intra DC or skip P fill
                fill_beat.mode <= cmd_reg.intra_picture ? SEC_FILL_INTRA_DC : SEC_FILL_SKIP_P;
                fill_active_reg <= 1'b1;
                state_reg <= ST_FILL;
              end
              else
              begin
                pipe_flush <= (codec_reg != SEC_CODEC_MPEG2);
                end_of_slice <= (codec_reg == SEC_CODEC_VC1);
                state_reg <= ST_IDLE;
              end
            end
            else if (mb_done && mb_last)
              state_reg <= slice_end ? ST_IDLE : ST_DRAIN;
          end
          ST_DRAIN:
          begin
            // surplus data flushed until slice end
            if (slice_end)
            begin
              pipe_flush <= (codec_reg != SEC_CODEC_MPEG2);
              state_reg <= (current_mb_position_reg >= pic_size_reg) ? ST_DONE : ST_IDLE;
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Watchdog counts cycles without progress while busy
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wdog_count_reg <= 32'h0000_0000;
      engine_reset <= 1'b0;
    end
    else
    begin
      engine_reset <= wdog_fire;
      if (progress || wdog_fire || state_reg == ST_IDLE || state_reg == ST_DONE)
        wdog_count_reg <= 32'h0000_0000;
      else
        wdog_count_reg <= wdog_count_reg + 32'h0000_0001;
    end
  end

  // Sticky status flags; a new event wins over a clear
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      slice_err_reg <= 1'b0;
      wdog_hit_reg <= 1'b0;
    end
    else
    begin
      if (vld_error || data_error || mpr_error)
        slice_err_reg <= 1'b1;
      else if (wr_go && awaddr_reg == SEC_ADDR_STATUS && wstrb_reg[0] && wdata_reg[SEC_STAT_SLICE_ERR_BIT])
        slice_err_reg <= 1'b0;
      if (wdog_fire)
        wdog_hit_reg <= 1'b1;
      else if (wr_go && awaddr_reg == SEC_ADDR_STATUS && wstrb_reg[0] && wdata_reg[SEC_STAT_WDOG_BIT])
        wdog_hit_reg <= 1'b0;
    end
  end

  // AXI write channels and register storage
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SEC_RESP_OKAY;
      ctrl_reg <= SEC_CTRL_RESET;
      pic_size_reg <= SEC_PIC_SIZE_RESET;
      wdog_limit_reg <= SEC_WDOG_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= SEC_RESP_OKAY;
        if (awaddr_reg == SEC_ADDR_CTRL)
          ctrl_reg <= sec_merge(ctrl_reg, wdata_reg, wstrb_reg);
        else if (awaddr_reg == SEC_ADDR_PIC_SIZE)
          pic_size_reg <= 16'(sec_merge({16'h0000, pic_size_reg}, wdata_reg, wstrb_reg));
        else if (awaddr_reg == SEC_ADDR_WDOG_LIMIT)
          wdog_limit_reg <= sec_merge(wdog_limit_reg, wdata_reg, wstrb_reg);
        else if (awaddr_reg != SEC_ADDR_STATUS && awaddr_reg != SEC_ADDR_CUR_POS &&
                 awaddr_reg != SEC_ADDR_PREV_COUNT)
          s_axi_bresp <= SEC_RESP_DECERR;
      end
    end
  end

  // AXI read channel; one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= SEC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= SEC_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == SEC_ADDR_CTRL)
        s_axi_rdata <= ctrl_reg;
      else if (s_axi_araddr == SEC_ADDR_PIC_SIZE)
        s_axi_rdata <= {16'h0000, pic_size_reg};
      else if (s_axi_araddr == SEC_ADDR_WDOG_LIMIT)
        s_axi_rdata <= wdog_limit_reg;
      else if (s_axi_araddr == SEC_ADDR_STATUS)
      begin
        s_axi_rdata[SEC_STAT_FILL_BIT] <= fill_active_reg;
        s_axi_rdata[SEC_STAT_SLICE_ERR_BIT] <= slice_err_reg;
        s_axi_rdata[SEC_STAT_DISCARD_BIT] <= discard_data;
        s_axi_rdata[SEC_STAT_WDOG_BIT] <= wdog_hit_reg;
      end
      else if (s_axi_araddr == SEC_ADDR_CUR_POS)
        s_axi_rdata <= {16'h0000, current_mb_position_reg};
      else if (s_axi_araddr == SEC_ADDR_PREV_COUNT)
        s_axi_rdata <= {16'h0000, prior_decoded_mb_count_reg};
      else
        s_axi_rresp <= SEC_RESP_DECERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_wdog_trip;
    wdog_fire ##1 engine_reset;
  endsequence

  a_fill_flag_state: assert property (fill_active_reg == (state_reg == ST_FILL))
    else $error("fill status disagrees with fill state");
  a_fill_in_picture: assert property (fill_valid |-> fill_beat.position < pic_size_reg)
    else $error("fill beat outside picture");
  a_decode_bound: assert property (decode_enable |-> current_mb_position_reg < pic_size_reg)
    else $error("decoding beyond picture size");
  a_mb_count: assert property (decode_enable && mb_done
    |=> current_mb_position_reg == $past(current_mb_position_reg) + 16'h0001)
    else $error("position not advanced by decoded macroblock");
  a_overlap_jump: assert property (state_reg == ST_CHECK && current_mb_position_reg < pic_size_reg
    && current_mb_position_reg > cmd_reg.slice_first_mb_position
    |=> current_mb_position_reg == $past(cmd_reg.slice_first_mb_position))
    else $error("overlap not resolved to slice start");
  a_match_go: assert property (state_reg == ST_CHECK && current_mb_position_reg < pic_size_reg
    && current_mb_position_reg == cmd_reg.slice_first_mb_position |=> decode_enable)
    else $error("matching slice did not decode");
  a_err_sticky: assert property (vld_error || data_error || mpr_error |=> slice_err_reg)
    else $error("slice error not flagged");
  a_wdog_reset: assert property (wdog_fire |-> s_wdog_trip ##0 (state_reg == ST_IDLE))
    else $error("watchdog did not reset engine");
  a_new_pic_zero: assert property (cmd_take && cmd.kind == SEC_CMD_SLICE && new_pic_reg && !wdog_fire
    |=> current_mb_position_reg == 16'h0000)
    else $error("position not cleared at new picture");
  a_mpeg2_flush: assert property (cmd_take && cmd.kind == SEC_CMD_PICTURE && cmd.codec == SEC_CODEC_MPEG2
    && !wdog_fire |=> pipe_flush)
    else $error("no flush on mpeg2 picture command");
endmodule : sec_top

// >>> sec_pkg.sv
/*
  Package for the slice error concealment block: register offsets, field positions,
  reset values, command and fill-beat layouts.
  Assumes a 32-bit AXI4-Lite register bus and 16-bit macroblock positions.
*/
package sec_pkg;
  // Register byte addresses
  localparam logic [7:0] SEC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SEC_ADDR_PIC_SIZE = 8'h04;
  localparam logic [7:0] SEC_ADDR_WDOG_LIMIT = 8'h08;
  localparam logic [7:0] SEC_ADDR_STATUS = 8'h0C;
  localparam logic [7:0] SEC_ADDR_CUR_POS = 8'h10;
  localparam logic [7:0] SEC_ADDR_PREV_COUNT = 8'h14;
  // Control fields
  localparam int SEC_CTRL_CONCEAL_BIT = 0;
  localparam int SEC_CTRL_MBAFF_BIT = 1;
  localparam int SEC_CTRL_REWIND_LSB = 8;
  localparam int SEC_CTRL_REWIND_MSB = 15;
  // Status fields
  localparam int SEC_STAT_FILL_BIT = 0;
  localparam int SEC_STAT_SLICE_ERR_BIT = 1;
  localparam int SEC_STAT_DISCARD_BIT = 2;
  localparam int SEC_STAT_WDOG_BIT = 3;
  // Reset values
  localparam logic [31:0] SEC_CTRL_RESET = 32'h0000_0801;
  localparam logic [15:0] SEC_PIC_SIZE_RESET = 16'h0000;
  localparam logic [31:0] SEC_WDOG_RESET = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] SEC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SEC_RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {SEC_CODEC_AVC, SEC_CODEC_VC1, SEC_CODEC_MPEG2} sec_codec_t;
  typedef enum logic {SEC_CMD_PICTURE, SEC_CMD_SLICE} sec_cmd_kind_t;
  typedef enum logic [1:0] {SEC_FILL_COPY, SEC_FILL_SKIP_P, SEC_FILL_INTRA_DC} sec_fill_mode_t;

  // Slice or picture-state command from the command streamer
  typedef struct packed {
    sec_cmd_kind_t kind;
    sec_codec_t codec;
    logic [15:0] slice_first_mb_position;
    logic [15:0] next_slice_first_mb_position;
    logic [23:0] data_len;
    logic [4:0] conceal_frame_store;
    logic intra_picture;
  } sec_cmd_t;

  // One concealed macroblock handed to the reconstruction back end
  typedef struct packed {
    logic [15:0] position;
    logic [4:0] frame_store;
    sec_fill_mode_t mode;
  } sec_fill_t;
endpackage : sec_pkg

// >>> sec_cmd_model.sv
/*
  Command streamer model: offers picture and slice commands on the valid/ready port.
  Assumes the block takes a command at the edge with cmd_valid and cmd_ready high.
*/
`timescale 1ns/100ps
module sec_cmd_model
  import sec_pkg::*;
(
  input wire logic mclk,
  output sec_cmd_t cmd,
  output logic cmd_valid,
  input wire logic cmd_ready
);
  // Next slice start carried in slice commands, set by the bench
  logic [15:0] next_start = 16'h0000;
  // Idle port at time zero
  initial
  begin
    cmd = '0;
    cmd_valid = 1'b0;
  end

  // codec changes only by picture commands
  task automatic send(input sec_cmd_kind_t k, input sec_codec_t c, input logic [15:0] sp,
                      input logic [23:0] len, input int gap);
    repeat (gap) @(posedge mclk);
    cmd <= '{k, c, sp, next_start, len, 5'h03, 1'b0};
    cmd_valid <= 1'b1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    // Released payload is inverted so a stale value never passes
    cmd <= ~cmd;
  endtask : send
endmodule : sec_cmd_model

// >>> slice_error_concealment_tb_top.sv
/*
  Self-checking bench for sec_top: register bus, gap fill, overlap, phantom, errors, watchdog.
  Assumes sec_cmd_model drives the command port; the bench plays decoder and back end.
*/
`timescale 1ns/100ps
module slice_error_concealment_tb_top
  import sec_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, hit;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic mb_done = 1'b0, slice_end = 1'b0, vld_error = 1'b0, data_error = 1'b0, mpr_error = 1'b0, fill_ready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_valid, cmd_ready;
  logic decode_enable, discard_data, fill_valid, pipe_flush, end_of_slice, engine_reset, stream_switch_ok;
  sec_cmd_t cmd;
  sec_fill_t fill_beat;
  sec_fill_t fq[$];
  int miscompares = 0, check_count = 0;

  // Clock and instances
  always #2 mclk = ~mclk;
  sec_top i_sec_top (.*);
  sec_cmd_model i_sec_cmd_model (.mclk(mclk), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));

  // Record every fill beat the back end accepts
  always @(posedge mclk)
    if (fill_valid === 1'b1 && fill_ready) fq.push_back(fill_beat);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Bus write: address and data together, response awaited
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : axw

  // Bus read into rd and rr
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : axr

  // Bounded wait for decode_enable, pipe_flush, engine_reset or discard_data
  task automatic wt(input int w, input int lim);
    logic [3:0] s;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++)
    begin
      @(posedge mclk);
      s = {discard_data, engine_reset, pipe_flush, decode_enable};
      hit = (s[w] === 1'b1);
    end
  endtask : wt

  // Decode n macroblocks then end the slice
  task automatic dec(input int n);
    mb_done <= 1'b1;
    repeat (n) @(posedge mclk);
    mb_done <= 1'b0;
    slice_end <= 1'b1;
    @(posedge mclk);
    slice_end <= 1'b0;
  endtask : dec

  task automatic t_regs;
    axr(SEC_ADDR_CTRL);
    chk("ctrl reset", rd, SEC_CTRL_RESET);
    axr(8'h20);
    chk("unmapped resp", rr, SEC_RESP_DECERR);
    axw(SEC_ADDR_PIC_SIZE, 32'h0000_0014);
    axw(SEC_ADDR_CTRL, 32'h0000_0201);
    axr(SEC_ADDR_PIC_SIZE);
    chk("pic size", rd, 32'h0000_0014);
    $display("test regs done");
  endtask : t_regs

  task automatic t_fill;
    i_sec_cmd_model.send(SEC_CMD_PICTURE, SEC_CODEC_AVC, 16'h0000, 24'h000000, 1);
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_AVC, 16'h0000, 24'h000100, 1);
    wt(0, 8);
    chk("match decode", hit, 1);
    dec(5);
    wt(1, 8);
    chk("slice flush", hit, 1);
    axr(SEC_ADDR_CUR_POS);
    chk("cur pos", rd, 32'h0000_0005);
    fq.delete();
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_AVC, 16'h000A, 24'h000100, 5);
    repeat (4) @(posedge mclk);
    axr(SEC_ADDR_STATUS);
    chk("fill busy", rd[SEC_STAT_FILL_BIT], 1);
    fill_ready <= 1'b1;
    wt(0, 40);
    fill_ready <= 1'b0;
    chk("fill count", fq.size(), 7);
    foreach (fq[i])
    begin
      chk("fill pos", 32'(fq[i].position), 3 + i);
      chk("fill store", 32'({fq[i].frame_store, fq[i].mode}), 32'({5'h03, SEC_FILL_COPY}));
    end
    axr(SEC_ADDR_STATUS);
    chk("fill idle", rd[SEC_STAT_FILL_BIT], 0);
    dec(4);
    $display("test fill done");
  endtask : t_fill

  task automatic t_tail;
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_AVC, 16'h000C, 24'h000100, 1);
    wt(0, 8);
    chk("stream switch busy", stream_switch_ok, 0);
    axr(SEC_ADDR_CUR_POS);
    chk("overlap pos", rd, 32'h0000_000C);
    dec(2);
    fq.delete();
    fill_ready <= 1'b1;
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_AVC, 16'h0014, 24'h000000, 1);
    for (int n = 0; n < 40 && fq.size() < 8; n++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    fill_ready <= 1'b0;
    chk("tail count", fq.size(), 8);
    chk("tail last", 32'(fq[$].position), 32'h0000_0013);
    chk("tail stop", decode_enable, 0);
    chk("stream switch", stream_switch_ok, 1);
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_AVC, 16'h0005, 24'h000010, 1);
    wt(3, 8);
    chk("discard", hit, 1);
    dec(1);
    i_sec_cmd_model.send(SEC_CMD_PICTURE, SEC_CODEC_MPEG2, 16'h0000, 24'h000000, 1);
    wt(1, 4);
    chk("picture flush", hit, 1);
    $display("test tail done");
  endtask : t_tail

  task automatic t_err;
    for (int k = 0; k < 3; k++)
    begin
      {mpr_error, data_error, vld_error} <= 3'b001 << k;
      @(posedge mclk);
      {mpr_error, data_error, vld_error} <= 3'b000;
      axr(SEC_ADDR_STATUS);
      chk("slice err", rd[SEC_STAT_SLICE_ERR_BIT], 1);
      axw(SEC_ADDR_STATUS, 32'h0000_0002);
    end
    $display("test err done");
  endtask : t_err

  task automatic t_vc1;
    i_sec_cmd_model.next_start = 16'h0008;
    i_sec_cmd_model.send(SEC_CMD_PICTURE, SEC_CODEC_VC1, 16'h0000, 24'h000000, 1);
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_VC1, 16'h0000, 24'h000010, 1);
    wt(0, 8);
    fq.delete();
    fill_ready <= 1'b1;
    dec(3);
    wt(1, 20);
    fill_ready <= 1'b0;
    chk("vc1 fill count", fq.size(), 5);
    chk("vc1 fill first", 32'(fq[0].position), 32'h0000_0003);
    chk("vc1 fill mode", 32'(fq[0].mode), 32'(SEC_FILL_SKIP_P));
    i_sec_cmd_model.next_start = 16'h000A;
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_VC1, 16'h0008, 24'h000010, 1);
    wt(0, 8);
    dec(4);
    axr(SEC_ADDR_CUR_POS);
    chk("vc1 stop", rd, 32'h0000_000A);
    axw(SEC_ADDR_CTRL, 32'h0000_0200);
    i_sec_cmd_model.next_start = 16'h000E;
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_VC1, 16'h000A, 24'h000010, 1);
    wt(0, 8);
    dec(1);
    @(posedge mclk);
    chk("vc1 hole", end_of_slice, 1);
    $display("test vc1 done");
  endtask : t_vc1

  task automatic t_wdog;
    axw(SEC_ADDR_WDOG_LIMIT, 32'h0000_0010);
    i_sec_cmd_model.send(SEC_CMD_PICTURE, SEC_CODEC_AVC, 16'h0000, 24'h000000, 1);
    i_sec_cmd_model.send(SEC_CMD_SLICE, SEC_CODEC_AVC, 16'h0000, 24'h000010, 1);
    axr(SEC_ADDR_CUR_POS);
    chk("new picture pos", rd, 32'h0000_0000);
    wt(2, 60);
    chk("stall reset", hit, 1);
    axr(SEC_ADDR_STATUS);
    chk("stall status", rd[SEC_STAT_WDOG_BIT], 1);
    $display("test wdog done");
  endtask : t_wdog

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_fill;
    t_tail;
    t_err;
    t_vc1;
    t_wdog;
    test_done;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    test_done;
  end
endmodule : slice_error_concealment_tb_top
